// file: hdl/mvm_debounce.sv
// Purpose: Debounce counter of the vector magnitude event
// Assumes: Result strobes come at the output data rate
// Notes:   In hybrid mode only every second result advances the count
`timescale 1ns/1ps
`default_nettype none
module mvm_debounce #(
  parameter int CNT_W = 8                   // Count width
) (
  input  wire logic             pclk,       // Clock
  input  wire logic             presetn,    // Async reset, low
  input  wire logic             enable,     // Function enabled
  input  wire logic             res_valid,  // Result strobe
  input  wire logic             res_above,  // Above threshold
  input  wire mvm_pkg::mvm_dbmode_t dbmode, // Counter mode
  input  wire logic             hybrid,     // Hybrid mode
  input  wire logic [CNT_W-1:0] limit,      // Debounce count
  output logic                  event_p,    // Event pulse
  output logic [CNT_W-1:0]      count       // Debounce counter
);
  logic phase_r;
  logic step;

  assign step = res_valid & (~hybrid | phase_r); // R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 1'b0;
    end else if (!hybrid || !enable) begin
      phase_r <= 1'b0;
    end else if (res_valid) begin
      phase_r <= ~phase_r; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!enable) begin
      count <= '0;
    end else if (step) begin
      if (res_above) begin
        if (count >= limit) begin
          count <= '0;
        end else begin
          count <= count + CNT_W'(1); // R4
        end
      end else begin
        case (dbmode)
          mvm_pkg::MVM_DB_DECREMENT: begin
            if (count != '0) begin
              count <= count - CNT_W'(1); // R1
            end
          end
          mvm_pkg::MVM_DB_CLEAR: begin
            count <= '0; // R2
          end
          default: begin
            count <= '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_p <= 1'b0;
    end else begin
      event_p <= enable & step & res_above & (count >= limit); // R9
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dec_below: assert property (enable && step && !res_above && dbmode == mvm_pkg::MVM_DB_DECREMENT
    && count != '0 |=> count == $past(count) - CNT_W'(1)) // R1
    else $error("count not decremented below threshold");
  a_clr_below: assert property (enable && step && !res_above && dbmode == mvm_pkg::MVM_DB_CLEAR
    |=> count == '0) // R2
    else $error("count not cleared below threshold");
  a_count_advance: assert property (enable && step && res_above && count < limit
    |=> count == $past(count) + CNT_W'(1) && !event_p) // R4
    else $error("count did not advance");
  a_hybrid_skip: assert property (enable && hybrid && res_valid && !phase_r
    |=> $stable(count) && !event_p) // R5
    else $error("hybrid sample advanced count");
  a_event_fire: assert property (enable && step && res_above && count >= limit |=> event_p) // R9
    else $error("event missing after debounce");
  c_event: cover property (event_p);
  c_hybrid_step: cover property (hybrid && step && res_above);
endmodule // mvm_debounce
`default_nettype wire

// file: hdl/mvm_magnitude.sv
// Purpose: Squared vector distance against squared threshold, one register stage
// Assumes: Sample inputs hold during the strobe cycle
// Notes:   Comparing squares avoids a square root
`timescale 1ns/1ps
`default_nettype none
module mvm_magnitude (
  input  wire logic              pclk,       // Clock
  input  wire logic              presetn,    // Async reset, low
  input  wire logic              smp_valid,  // Sample strobe
  input  wire mvm_pkg::mvm_axis_t cur_x,     // Current X
  input  wire mvm_pkg::mvm_axis_t cur_y,     // Current Y
  input  wire mvm_pkg::mvm_axis_t cur_z,     // Current Z
  input  wire mvm_pkg::mvm_axis_t ref_x,     // Reference X
  input  wire mvm_pkg::mvm_axis_t ref_y,     // Reference Y
  input  wire mvm_pkg::mvm_axis_t ref_z,     // Reference Z
  input  wire logic [14:0]       ths,        // Threshold, 0.1 uT per LSB
  output logic                   res_valid,  // Result strobe
  output logic                   res_above   // Distance above threshold
);
  logic signed [16:0] dx;
  logic signed [16:0] dy;
  logic signed [16:0] dz;
  logic [33:0]        sx;
  logic [33:0]        sy;
  logic [33:0]        sz;
  logic [35:0]        dist2;
  logic [29:0]        ths_wide;
  logic [29:0]        ths2;

  assign dx       = $signed({cur_x[15], cur_x}) - $signed({ref_x[15], ref_x});
  assign dy       = $signed({cur_y[15], cur_y}) - $signed({ref_y[15], ref_y});
  assign dz       = $signed({cur_z[15], cur_z}) - $signed({ref_z[15], ref_z});
  assign sx       = 34'(dx * dx);
  assign sy       = 34'(dy * dy);
  assign sz       = 34'(dz * dz);
  assign dist2    = 36'(sx) + 36'(sy) + 36'(sz);
  assign ths_wide = {15'h0000, ths};
  assign ths2     = ths_wide * ths_wide;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_above <= 1'b0;
    end else begin
      res_valid <= smp_valid;
      res_above <= dist2 > {6'h00, ths2}; // R9
    end
  end

  a_dist_result: assert property (@(posedge pclk) disable iff (!presetn)
    smp_valid |=> res_valid && (res_above == $past(dist2 > {6'h00, ths2}))) // R9
    else $error("magnitude result wrong");
endmodule // mvm_magnitude
`default_nettype wire

// file: hdl/mvm_map.svh
// Purpose: Register indices, field positions, reset values and timing counts of the vector magnitude block
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef MVM_MAP_SVH
`define MVM_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices
`define MVM_IDX_CFG       8'h69
`define MVM_IDX_THS_HI    8'h6A
`define MVM_IDX_THS_LO    8'h6B
`define MVM_IDX_CNT       8'h6C
`define MVM_IDX_INITX_HI  8'h6D
`define MVM_IDX_INITX_LO  8'h6E
`define MVM_IDX_INITY_HI  8'h6F
`define MVM_IDX_INITY_LO  8'h70
`define MVM_IDX_INITZ_HI  8'h71
`define MVM_IDX_INITZ_LO  8'h72
`define MVM_IDX_STATUS    8'h80
`define MVM_IDX_MASK      8'h81
`define MVM_IDX_MODE      8'h82

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define MVM_CFG_INITM     5
`define MVM_CFG_UPDM      4
`define MVM_CFG_EN        3
`define MVM_THS_DBCNTM    7
`define MVM_STAT_VECM     0
`define MVM_MODE_HYBRID   0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define MVM_RST_BYTE      8'h00
`define MVM_RST_CFG       7'h00
`define MVM_RST_AXIS      16'h0000

////////////////////////////////////////////////////////////////////////////////
// Timing counts
`define MVM_APB_WAIT      1

`endif

// file: hdl/mvm_pkg.sv
// Purpose: Shared types of the vector magnitude block
// Assumes: Nothing
// Notes:   Constants live in mvm_map.svh
package mvm_pkg;
  typedef logic [15:0] mvm_axis_t;
  typedef logic [7:0]  mvm_byte_t;
  typedef enum logic {MVM_DB_DECREMENT, MVM_DB_CLEAR} mvm_dbmode_t;
endpackage

// file: hdl/mvm_top.sv
// Purpose: Vector magnitude change detector with APB registers and a sticky interrupt
// Assumes: mag_valid strobes are at least three clocks apart
// Notes:   Registers sit at byte address four times their index
//
// Summary of operation
// R1: Mode 0: each below-threshold sample decrements the debounce counter by one.
// R2: Mode 1: each below-threshold sample clears the debounce counter.
// R3: Threshold is 15-bit unsigned; upper seven bits under the mode bit.
// R4: Debounce count is in sample periods of the output data rate.
// R5: Hybrid mode advances the debounce at half the sample rate.
// R6: Initial X reference is signed 16-bit from high and low bytes.
// R7: Initial Y reference is signed 16-bit from high and low bytes.
// R8: Initial Z reference is signed 16-bit from high and low bytes.
// R9: Event when distance to reference exceeds threshold longer than the count.
// R10: On enable, load references from live data or from initial registers.
`include "mvm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mvm_top (
  input  wire logic              pclk,       // APB clock, 250 MHz
  input  wire logic              presetn,    // Async reset, low
  input  wire logic              psel,       // APB select
  input  wire logic              penable,    // APB enable
  input  wire logic              pwrite,     // APB write
  input  wire logic [11:0]       paddr,      // APB byte address
  input  wire logic [31:0]       pwdata,     // APB write data
  output logic [31:0]            prdata,     // APB read data
  output logic                   pready,     // APB ready
  output logic                   pslverr,    // APB error, unmapped address
  input  wire logic              mag_valid,  // Magnetic sample strobe
  input  wire mvm_pkg::mvm_axis_t mag_x,     // Magnetic X output
  input  wire mvm_pkg::mvm_axis_t mag_y,     // Magnetic Y output
  input  wire mvm_pkg::mvm_axis_t mag_z,     // Magnetic Z output
  output logic                   irq,        // Interrupt, high level
  output logic                   vecm_event  // Event pulse
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  mvm_pkg::mvm_byte_t ths_hi_r;
  mvm_pkg::mvm_byte_t ths_lo_r;
  mvm_pkg::mvm_byte_t cnt_r;
  mvm_pkg::mvm_byte_t initx_hi_r;
  mvm_pkg::mvm_byte_t initx_lo_r;
  mvm_pkg::mvm_byte_t inity_hi_r;
  mvm_pkg::mvm_byte_t inity_lo_r;
  mvm_pkg::mvm_byte_t initz_hi_r;
  mvm_pkg::mvm_byte_t initz_lo_r;
  logic [6:0]         cfg_r;
  logic               status_r;
  logic               mask_r;
  logic               hybrid_r;

  mvm_pkg::mvm_axis_t ref_x_r;
  mvm_pkg::mvm_axis_t ref_y_r;
  mvm_pkg::mvm_axis_t ref_z_r;
  mvm_pkg::mvm_axis_t last_x_r;
  mvm_pkg::mvm_axis_t last_y_r;
  mvm_pkg::mvm_axis_t last_z_r;
  logic               en_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // Decoded views
  logic [7:0]         idx;
  logic               access;
  logic               wr_en;
  logic               mapped;
  logic [31:0]        rd_nxt;
  logic [14:0]        ths;
  mvm_pkg::mvm_axis_t init_x;
  mvm_pkg::mvm_axis_t init_y;
  mvm_pkg::mvm_axis_t init_z;
  logic               func_en;
  logic               initm;
  logic               updm;
  logic               en_rise;
  logic               res_valid;
  logic               res_above;
  logic               db_event;
  logic [7:0]         db_count;
  mvm_pkg::mvm_dbmode_t dbmode;

  assign idx     = paddr[9:2];
  assign access  = psel & penable & pready;
  assign wr_en   = access & pwrite & mapped;
  assign ths     = {ths_hi_r[6:0], ths_lo_r}; // R3
  assign init_x  = {initx_hi_r, initx_lo_r}; // R6
  assign init_y  = {inity_hi_r, inity_lo_r}; // R7
  assign init_z  = {initz_hi_r, initz_lo_r}; // R8
  assign func_en = cfg_r[`MVM_CFG_EN];
  assign initm   = cfg_r[`MVM_CFG_INITM];
  assign updm    = cfg_r[`MVM_CFG_UPDM];
  assign en_rise = func_en & ~en_prev_r;
  assign dbmode  = ths_hi_r[`MVM_THS_DBCNTM] ? mvm_pkg::MVM_DB_CLEAR : mvm_pkg::MVM_DB_DECREMENT; // R1 R2

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (idx)
      `MVM_IDX_CFG:      rd_nxt[6:0] = cfg_r;
      `MVM_IDX_THS_HI:   rd_nxt[7:0] = ths_hi_r;
      `MVM_IDX_THS_LO:   rd_nxt[7:0] = ths_lo_r;
      `MVM_IDX_CNT:      rd_nxt[7:0] = cnt_r;
      `MVM_IDX_INITX_HI: rd_nxt[7:0] = initx_hi_r;
      `MVM_IDX_INITX_LO: rd_nxt[7:0] = initx_lo_r;
      `MVM_IDX_INITY_HI: rd_nxt[7:0] = inity_hi_r;
      `MVM_IDX_INITY_LO: rd_nxt[7:0] = inity_lo_r;
      `MVM_IDX_INITZ_HI: rd_nxt[7:0] = initz_hi_r;
      `MVM_IDX_INITZ_LO: rd_nxt[7:0] = initz_lo_r;
      `MVM_IDX_STATUS:   rd_nxt[`MVM_STAT_VECM] = status_r;
      `MVM_IDX_MASK:     rd_nxt[`MVM_STAT_VECM] = mask_r;
      `MVM_IDX_MODE:     rd_nxt[`MVM_MODE_HYBRID] = hybrid_r;
      default:           mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0) begin
      mapped = 1'b0;
      rd_nxt = 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r      <= `MVM_RST_CFG;
      ths_hi_r   <= `MVM_RST_BYTE;
      ths_lo_r   <= `MVM_RST_BYTE;
      cnt_r      <= `MVM_RST_BYTE;
      initx_hi_r <= `MVM_RST_BYTE;
      initx_lo_r <= `MVM_RST_BYTE;
      inity_hi_r <= `MVM_RST_BYTE;
      inity_lo_r <= `MVM_RST_BYTE;
      initz_hi_r <= `MVM_RST_BYTE;
      initz_lo_r <= `MVM_RST_BYTE;
      mask_r     <= 1'b0;
      hybrid_r   <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        `MVM_IDX_CFG:      cfg_r      <= pwdata[6:0];
        `MVM_IDX_THS_HI:   ths_hi_r   <= pwdata[7:0]; // R3
        `MVM_IDX_THS_LO:   ths_lo_r   <= pwdata[7:0];
        `MVM_IDX_CNT:      cnt_r      <= pwdata[7:0]; // R4
        `MVM_IDX_INITX_HI: initx_hi_r <= pwdata[7:0];
        `MVM_IDX_INITX_LO: initx_lo_r <= pwdata[7:0];
        `MVM_IDX_INITY_HI: inity_hi_r <= pwdata[7:0];
        `MVM_IDX_INITY_LO: inity_lo_r <= pwdata[7:0];
        `MVM_IDX_INITZ_HI: initz_hi_r <= pwdata[7:0];
        `MVM_IDX_INITZ_LO: initz_lo_r <= pwdata[7:0];
        `MVM_IDX_MASK:     mask_r     <= pwdata[`MVM_STAT_VECM];
        `MVM_IDX_MODE:     hybrid_r   <= pwdata[`MVM_MODE_HYBRID];
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Last sample, held for reference update on an event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_x_r <= `MVM_RST_AXIS;
      last_y_r <= `MVM_RST_AXIS;
      last_z_r <= `MVM_RST_AXIS;
    end else if (mag_valid) begin
      last_x_r <= mag_x;
      last_y_r <= mag_y;
      last_z_r <= mag_z;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Internal references, not readable by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= func_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_x_r <= `MVM_RST_AXIS;
      ref_y_r <= `MVM_RST_AXIS;
      ref_z_r <= `MVM_RST_AXIS;
    end else if (en_rise) begin
      if (initm) begin
        ref_x_r <= init_x; // R6 R10
        ref_y_r <= init_y; // R7 R10
        ref_z_r <= init_z; // R8 R10
      end else begin
        ref_x_r <= mag_x; // R10
        ref_y_r <= mag_y;
        ref_z_r <= mag_z;
      end
    end else if (func_en && initm && updm) begin
      ref_x_r <= init_x; // R6
      ref_y_r <= init_y; // R7
      ref_z_r <= init_z; // R8
    end else if (db_event && !updm) begin
      ref_x_r <= last_x_r;
      ref_y_r <= last_y_r;
      ref_z_r <= last_z_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Detection datapath
  mvm_magnitude u_mag (
    .pclk      (pclk),
    .presetn   (presetn),
    .smp_valid (mag_valid & func_en & ~en_rise),
    .cur_x     (mag_x),
    .cur_y     (mag_y),
    .cur_z     (mag_z),
    .ref_x     (ref_x_r),
    .ref_y     (ref_y_r),
    .ref_z     (ref_z_r),
    .ths       (ths),
    .res_valid (res_valid),
    .res_above (res_above)
  );

  mvm_debounce #(
    .CNT_W (8)
  ) u_db (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (func_en),
    .res_valid (res_valid),
    .res_above (res_above),
    .dbmode    (dbmode),
    .hybrid    (hybrid_r),
    .limit     (cnt_r),
    .event_p   (db_event),
    .count     (db_count)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 1'b0;
    end else if (db_event) begin
      status_r <= 1'b1; // R9
    end else if (wr_en && idx == `MVM_IDX_STATUS && pwdata[`MVM_STAT_VECM]) begin
      status_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq        <= 1'b0;
      vecm_event <= 1'b0;
    end else begin
      irq        <= status_r & mask_r;
      vecm_event <= db_event; // R9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse");
  a_unmapped_error: assert property (psel && penable && !pready && !mapped |=> pready && pslverr)
    else $error("unmapped access without error");
  a_ths_write: assert property (wr_en && idx == `MVM_IDX_THS_HI
    |=> ths[14:8] == $past(pwdata[6:0]) && dbmode == mvm_pkg::mvm_dbmode_t'($past(pwdata[7]))) // R3
    else $error("threshold high field not stored");
  a_ref_live_load: assert property (en_rise && !initm
    |=> ref_x_r == $past(mag_x) && ref_y_r == $past(mag_y) && ref_z_r == $past(mag_z)) // R10
    else $error("live reference not loaded on enable");
  a_ref_x_init: assert property (en_rise && initm |=> ref_x_r == $past(init_x)) // R6
    else $error("initial X reference not loaded");
  a_ref_y_init: assert property (en_rise && initm |=> ref_y_r == $past(init_y)) // R7
    else $error("initial Y reference not loaded");
  a_ref_z_init: assert property (en_rise && initm |=> ref_z_r == $past(init_z)) // R8
    else $error("initial Z reference not loaded");
  a_event_status: assert property (db_event |=> status_r && vecm_event ##1 (irq == mask_r)) // R9
    else $error("event not reflected in status and interrupt");
  a_irq_level: assert property (!status_r |=> !irq)
    else $error("interrupt without status");

  //////////////////////////////////////////////////////////////////////////////
  // Reference, status and register checks
  a_ref_event_update: assert property (db_event && !updm && !en_rise // R9
    |=> ref_x_r == $past(last_x_r) && ref_y_r == $past(last_y_r) && ref_z_r == $past(last_z_r))
    else $error("reference not moved to last sample");
  a_ref_follow_init: assert property (func_en && initm && updm // R6 R7 R8
    |=> ref_x_r == $past(init_x) && ref_y_r == $past(init_y) && ref_z_r == $past(init_z))
    else $error("reference not following initial values");
  a_no_result_off: assert property (!func_en |=> !res_valid) // R10
    else $error("result while disabled");
  a_count_disabled: assert property (!func_en |=> db_count == 8'h00) // R4
    else $error("debounce count not zero while disabled");

  a_status_sticky: assert property (status_r // R9
    && !(wr_en && idx == `MVM_IDX_STATUS && pwdata[`MVM_STAT_VECM]) |=> status_r)
    else $error("status lost without clear");
  a_status_clear: assert property (!db_event && wr_en && idx == `MVM_IDX_STATUS
    && pwdata[`MVM_STAT_VECM] |=> !status_r)
    else $error("status not cleared");
  a_irq_follow: assert property (status_r && mask_r |=> irq)
    else $error("interrupt missing");

  a_wr_unmapped: assert property (access && pwrite && !mapped
    |=> $stable(cfg_r) && $stable(cnt_r) && $stable(mask_r))
    else $error("unmapped write changed a register");
  a_read_count: assert property (psel && penable && !pready && !pwrite && idx == `MVM_IDX_CNT // R4
    && paddr[11:10] == 2'h0 |=> prdata == {24'h000000, $past(cnt_r)})
    else $error("debounce count read wrong");
  a_ths_low_write: assert property (wr_en && idx == `MVM_IDX_THS_LO // R3
    |=> ths[7:0] == $past(pwdata[7:0]))
    else $error("threshold low byte not stored");
  a_init_x_write: assert property (wr_en && idx == `MVM_IDX_INITX_HI // R6
    |=> init_x[15:8] == $past(pwdata[7:0]))
    else $error("initial X high byte not stored");
  a_init_z_write: assert property (wr_en && idx == `MVM_IDX_INITZ_LO // R8
    |=> init_z[7:0] == $past(pwdata[7:0]))
    else $error("initial Z low byte not stored");
  c_init_load: cover property (en_rise && initm);
  c_status_clear: cover property (status_r ##1 !status_r);
  c_irq: cover property (irq);
endmodule // mvm_top
`default_nettype wire

// file: tb/mvm_top_tb.sv
// Purpose: Self-checking bench of the vector magnitude block
// Assumes: Samples and threshold share one 0.1 uT scale
// Notes:   Each scenario is a task that drives APB, and samples in all but t_regs, then judges
`include "mvm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mvm_top_tb;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               mag_valid;
  mvm_pkg::mvm_axis_t mag_x;
  mvm_pkg::mvm_axis_t mag_y;
  mvm_pkg::mvm_axis_t mag_z;
  logic               irq;
  logic               vecm_event;
  int                 mismatches;
  int                 compares;
  // Enable with init-register refs and no ref update on event
  localparam logic [7:0]  CFG_RUN  = 8'h38;
  localparam logic [7:0]  CFG_LIVE = 8'h18;
  localparam logic [15:0] REFX     = 16'hFF00;
  localparam logic [15:0] REFY     = 16'h0123;
  localparam logic [15:0] REFZ     = 16'hFE80;
  // Distance 200 and 600 around a threshold of 400
  localparam logic [15:0] NEARX    = 16'hFFC8;
  localparam logic [15:0] FARX     = 16'h0158;

  mvm_top i_mvm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mag_valid(mag_valid), .mag_x(mag_x), .mag_y(mag_y), .mag_z(mag_z), .irq(irq), .vecm_event(vecm_event));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, wd, r, e);
  endtask

  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(name, {eerr, 23'h0, exp}, {e, r[30:0]});
  endtask

  // One sample strobe, then count event pulses over the answer window
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z, input logic exp);
    int n;
    n = 0;
    @(posedge pclk);
    mag_valid <= 1'b1;
    mag_x <= x;
    mag_y <= y;
    mag_z <= z;
    @(posedge pclk);
    mag_valid <= 1'b0;
    repeat (5) begin
      @(posedge pclk);
      if (vecm_event === 1'b1) n++;
    end
    chk("vecm_event count", {31'h0, exp}, n);
  endtask

  task automatic cfg(input logic [7:0] thi, input logic [7:0] cnt, input logic [7:0] c);
    wr(`MVM_IDX_THS_HI, thi);
    wr(`MVM_IDX_THS_LO, 8'h90);
    wr(`MVM_IDX_CNT, cnt);
    wr(`MVM_IDX_CFG, 8'h00);
    wr(`MVM_IDX_CFG, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc("ths_hi reset", `MVM_IDX_THS_HI, 8'h00, 1'b0);
    rdc("cnt reset", `MVM_IDX_CNT, 8'h00, 1'b0);
    rdc("initx_lo reset", `MVM_IDX_INITX_LO, 8'h00, 1'b0);
    rdc("inity_hi reset", `MVM_IDX_INITY_HI, 8'h00, 1'b0);
    rdc("initz_lo reset", `MVM_IDX_INITZ_LO, 8'h00, 1'b0);
    rdc("mask reset", `MVM_IDX_MASK, 8'h00, 1'b0);
    rdc("unmapped", 8'h10, 8'h00, 1'b1);
    wr(`MVM_IDX_THS_HI, 8'hFF);
    rdc("ths_hi rw", `MVM_IDX_THS_HI, 8'hFF, 1'b0);
    wr(`MVM_IDX_CNT, 8'hA5);
    rdc("cnt rw", `MVM_IDX_CNT, 8'hA5, 1'b0);
  endtask

  task automatic t_refs();
    wr(`MVM_IDX_INITX_HI, REFX[15:8]);
    wr(`MVM_IDX_INITX_LO, REFX[7:0]);
    wr(`MVM_IDX_INITY_HI, REFY[15:8]);
    wr(`MVM_IDX_INITY_LO, REFY[7:0]);
    wr(`MVM_IDX_INITZ_HI, REFZ[15:8]);
    wr(`MVM_IDX_INITZ_LO, REFZ[7:0]);
    cfg(8'h01, 8'h00, CFG_RUN);
    smp(REFX, REFY, REFZ, 1'b0);
    smp(NEARX, REFY, REFZ, 1'b0);
    smp(FARX, REFY, REFZ, 1'b1);
  endtask

  // Count of 2: two above, one below, then above until the event
  task automatic t_db(input logic mode);
    cfg({mode, 7'h01}, 8'h02, CFG_RUN);
    for (int i = 0; i < 6; i++) begin
      smp((i == 2) ? NEARX : FARX, REFY, REFZ, mode ? (i == 5) : (i == 4));
    end
  endtask

  task automatic t_hyb();
    wr(`MVM_IDX_MODE, 8'h01);
    cfg(8'h01, 8'h00, CFG_RUN);
    for (int i = 0; i < 4; i++) begin
      smp(FARX, REFY, REFZ, i[0]);
    end
    wr(`MVM_IDX_MODE, 8'h00);
  endtask

  task automatic t_live();
    mag_x <= 16'h01F4;
    mag_y <= 16'h0000;
    mag_z <= 16'h0000;
    cfg(8'h01, 8'h00, CFG_LIVE);
    smp(16'h01F4, 16'h0000, 16'h0000, 1'b0);
    smp(16'h044C, 16'h0000, 16'h0000, 1'b1);
    // Live refs with update on event: the event moves the reference
    cfg(8'h01, 8'h00, 8'h08);
    smp(16'h01F4, 16'h0000, 16'h0000, 1'b1);
    smp(16'h01F4, 16'h0000, 16'h0000, 1'b0);
  endtask

  task automatic t_irq();
    wr(`MVM_IDX_STATUS, 8'h01);
    cfg(8'h01, 8'h00, CFG_RUN);
    smp(FARX, REFY, REFZ, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc("status set", `MVM_IDX_STATUS, 8'h01, 1'b0);
    wr(`MVM_IDX_MASK, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`MVM_IDX_STATUS, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("status cleared", `MVM_IDX_STATUS, 8'h00, 1'b0);
    wr(`MVM_IDX_CFG, 8'h00);
    smp(FARX, REFY, REFZ, 1'b0);
    rdc("status disabled", `MVM_IDX_STATUS, 8'h00, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    compares = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mag_valid = 1'b0;
    mag_x = 16'h0000;
    mag_y = 16'h0000;
    mag_z = 16'h0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_refs();
    t_db(1'b0);
    t_db(1'b1);
    t_hyb();
    t_live();
    t_irq();
    give_verdict();
  end

  // Whole run is a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule // mvm_top_tb
`default_nettype wire
